/* File: rtl/pbcd_regs.sv */
// bist error count, packet generator settings and cable diagnostic registers
// What this block does
// (R01) The upper byte of the first test register shows the count of erroneous bytes seen by the prbs checker.
// (R02) A software write to either of the two low bits of the bist control register freezes the shown count.
// (R03) With counting mode zero the error counter saturates at its maximum instead of wrapping.
// (R04) Writing one to bit 15 of the first test register captures the count for reads and clears the counter.
// (R05) The low byte of the first test register sets the generator idle gap in bytes, resetting to 125.
// (R06) An eleven-bit field of the second test register sets the generated packet length, resetting to 1500.
// (R07) Reserved bits ignore writes and read as zero.
// (R08) Writing one to bit 15 of the cable register starts a measurement; while zero the engine stays idle.
// (R09) The start bit clears itself when the completion flag is raised.
// (R10) A read-only two-bit grade field encodes link quality: 01 good, 10 medium, 11 poor, 00 reserved.
// (R11) Software trusts the grade only while the link status bit of the phy status register is one.
// (R12) A read-only done flag at bit 1 of the cable register is set when a measurement finishes.
// (R13) A read-only fail flag at bit 0 of the cable register is set when a measurement fails.
// (R14) Starting a new measurement clears the done and fail flags.
`timescale 1ns/1ps
`include "pbcd_params.svh"

module pbcd_regs (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [`PBCD_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic bist_err_byte,
  input wire logic bist_cnt_mode,
  output logic [7:0] bist_gap_len,
  output logic [10:0] bist_pkt_len,
  output logic diag_start,
  input wire logic diag_done,
  input wire logic diag_fail,
  input wire logic [1:0] diag_grade,
  output logic irq
);

  logic [7:0] err_cnt_r;
  logic [7:0] err_cnt_nxt;
  logic [7:0] err_shown_r;
  logic [7:0] err_shown_nxt;
  logic frozen_r;
  logic [7:0] gap_r;
  logic [10:0] len_r;
  logic start_r;
  logic done_r;
  logic fail_r;
  logic [1:0] grade_r;
  logic [`PBCD_IRQ_W-1:0] irq_stat_r;
  logic [`PBCD_IRQ_W-1:0] irq_mask_r;
  logic [`PBCD_IRQ_W-1:0] irq_ev;
  logic [`PBCD_IRQ_W-1:0] irq_clr;
  logic [15:0] errgap_word;
  logic [15:0] pktlen_word;
  logic [15:0] cable_word;
  logic [15:0] stat_word;
  logic [15:0] mask_word;
  logic [15:0] rd_mux;
  logic [15:0] rdata_r;
  logic irq_r;
  pbcd_pkg::pbcd_diag_state_t st_r;
  pbcd_pkg::pbcd_diag_state_t st_nxt;

  function automatic logic hit(input logic [`PBCD_ADDR_W-1:0] a, input logic [`PBCD_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // write and read decode; bist control writes are only snooped, that register lives elsewhere
  wire wr_errgap = reg_wr && hit(reg_addr, `PBCD_OFF_ERRGAP);
  wire wr_pktlen = reg_wr && hit(reg_addr, `PBCD_OFF_PKTLEN);
  wire wr_cable = reg_wr && hit(reg_addr, `PBCD_OFF_CABLE);
  wire wr_stat = reg_wr && hit(reg_addr, `PBCD_OFF_IRQ_STAT);
  wire wr_mask = reg_wr && hit(reg_addr, `PBCD_OFF_IRQ_MASK);
  wire wr_bctl = reg_wr && hit(reg_addr, `PBCD_OFF_BIST_CTRL);
  wire rd_errgap = hit(reg_addr, `PBCD_OFF_ERRGAP);
  wire rd_pktlen = hit(reg_addr, `PBCD_OFF_PKTLEN);
  wire rd_cable = hit(reg_addr, `PBCD_OFF_CABLE);
  wire rd_stat = hit(reg_addr, `PBCD_OFF_IRQ_STAT);
  wire rd_mask = hit(reg_addr, `PBCD_OFF_IRQ_MASK);

  // error counter control
  wire freeze_req = wr_bctl && (|reg_wdata[`PBCD_LOCK_MSB:0]); // R02
  wire capture_req = wr_errgap && reg_wdata[`PBCD_BIT_TOP]; // R04
  wire lock_req = capture_req || freeze_req;
  wire at_max = (err_cnt_r == `PBCD_CNT_MAX);
  wire sat_hold = at_max && !bist_cnt_mode; // R03
  wire cnt_inc = bist_err_byte && !sat_hold;
  wire sat_hit = bist_err_byte && sat_hold;

  // cable diagnostic control; a start written while running is ignored
  wire diag_idle = (st_r == pbcd_pkg::PBCD_DIAG_IDLE);
  wire diag_run = (st_r == pbcd_pkg::PBCD_DIAG_RUN);
  wire start_req = wr_cable && reg_wdata[`PBCD_BIT_TOP] && diag_idle; // R08
  wire finish = diag_run && (diag_done || diag_fail);

  // capture wins over an increment in the same cycle
  assign err_cnt_nxt = capture_req ? `PBCD_ZERO_CNT : (cnt_inc ? err_cnt_r + `PBCD_CNT_ONE : err_cnt_r); // R03 R04
  // shown count follows the counter until locked, and stays locked until reset
  assign err_shown_nxt = lock_req ? err_cnt_r : (frozen_r ? err_shown_r : err_cnt_nxt); // R01 R02 R04

  assign irq_ev[`PBCD_IRQ_DONE] = finish;
  assign irq_ev[`PBCD_IRQ_FAIL] = finish && diag_fail;
  assign irq_ev[`PBCD_IRQ_SAT] = sat_hit;
  assign irq_clr = wr_stat ? reg_wdata[`PBCD_IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      err_cnt_r <= `PBCD_ZERO_CNT;
    end else begin
      err_cnt_r <= err_cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      err_shown_r <= `PBCD_ZERO_CNT;
    end else begin
      err_shown_r <= err_shown_nxt;
    end
  end

  // lock flag for the shown count
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frozen_r <= 1'h0;
    end else if (lock_req) begin
      frozen_r <= 1'h1;
    end
  end

  // packet generator settings
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= `PBCD_GAP_RST;
    end else if (wr_errgap) begin
      gap_r <= reg_wdata[`PBCD_GAP_MSB:0]; // R05
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      len_r <= `PBCD_LEN_RST;
    end else if (wr_pktlen) begin
      len_r <= reg_wdata[`PBCD_LEN_MSB:0]; // R06 R07
    end
  end

  // diagnostic engine sequencing
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= pbcd_pkg::PBCD_DIAG_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      pbcd_pkg::PBCD_DIAG_IDLE: begin
        if (start_req) begin
          st_nxt = pbcd_pkg::PBCD_DIAG_RUN; // R08
        end
      end
      pbcd_pkg::PBCD_DIAG_RUN: begin
        if (finish) begin
          st_nxt = pbcd_pkg::PBCD_DIAG_IDLE; // R09
        end
      end
      default: begin
        st_nxt = pbcd_pkg::PBCD_DIAG_IDLE;
      end
    endcase
  end

  // start bit, cleared by hardware on completion
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      start_r <= 1'h0;
    end else if (start_req) begin
      start_r <= 1'h1; // R08
    end else if (finish) begin
      start_r <= 1'h0; // R09
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done_r <= 1'h0;
    end else if (start_req) begin
      done_r <= 1'h0; // R14
    end else if (finish) begin
      done_r <= 1'h1; // R12
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fail_r <= 1'h0;
    end else if (start_req) begin
      fail_r <= 1'h0; // R14
    end else if (finish) begin
      fail_r <= diag_fail; // R13
    end
  end

  // grade keeps the last completed result; software trusts it only with the link up
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      grade_r <= '0;
    end else if (finish) begin
      grade_r <= diag_grade; // R10
    end
  end

  // sticky status bits; a new event wins over a write-one clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `PBCD_IRQ_W; gi++) begin : g_irq_stat
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          irq_stat_r[gi] <= 1'h0;
        end else if (irq_ev[gi]) begin
          irq_stat_r[gi] <= 1'h1;
        end else if (irq_clr[gi]) begin
          irq_stat_r[gi] <= 1'h0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_r <= '0;
    end else if (wr_mask) begin
      irq_mask_r <= reg_wdata[`PBCD_IRQ_W-1:0];
    end
  end

  // irq lags the status by one cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // reserved bits are never set, so they read zero
  always_comb begin
    errgap_word = `PBCD_ZERO_WORD; // R07
    errgap_word[`PBCD_CNT_MSB:`PBCD_CNT_LSB] = err_shown_r; // R01
    errgap_word[`PBCD_GAP_MSB:0] = gap_r; // R05
  end

  always_comb begin
    pktlen_word = `PBCD_ZERO_WORD; // R07
    pktlen_word[`PBCD_LEN_MSB:0] = len_r; // R06
  end

  always_comb begin
    cable_word = `PBCD_ZERO_WORD; // R07
    cable_word[`PBCD_BIT_TOP] = start_r; // R08
    cable_word[`PBCD_GRADE_MSB:`PBCD_GRADE_LSB] = grade_r; // R10
    cable_word[`PBCD_BIT_DONE] = done_r; // R12
    cable_word[`PBCD_BIT_FAIL] = fail_r; // R13
  end

  always_comb begin
    stat_word = `PBCD_ZERO_WORD;
    stat_word[`PBCD_IRQ_W-1:0] = irq_stat_r;
  end

  always_comb begin
    mask_word = `PBCD_ZERO_WORD;
    mask_word[`PBCD_IRQ_W-1:0] = irq_mask_r;
  end

  // unmapped addresses read zero
  assign rd_mux = rd_errgap ? errgap_word :
                  rd_pktlen ? pktlen_word :
                  rd_cable ? cable_word :
                  rd_stat ? stat_word :
                  rd_mask ? mask_word :
                  `PBCD_ZERO_WORD; // R07

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= `PBCD_ZERO_WORD;
    end else begin
      rdata_r <= reg_rd ? rd_mux : `PBCD_ZERO_WORD;
    end
  end

  // every output comes straight from a flop
  assign reg_rdata = rdata_r;
  assign bist_gap_len = gap_r;
  assign bist_pkt_len = len_r;
  assign diag_start = start_r;
  assign irq = irq_r;

endmodule : pbcd_regs

/* File: include/pbcd_params.svh */
// register offsets, field positions, reset values and interrupt layout
`ifndef PBCD_PARAMS_SVH
`define PBCD_PARAMS_SVH
`define PBCD_ADDR_W 5
`define PBCD_OFF_ERRGAP 5'h1b
`define PBCD_OFF_PKTLEN 5'h1c
`define PBCD_OFF_CABLE 5'h1e
`define PBCD_OFF_IRQ_STAT 5'h08
`define PBCD_OFF_IRQ_MASK 5'h09
`define PBCD_OFF_BIST_CTRL 5'h16
`define PBCD_GAP_RST 8'h7d
`define PBCD_LEN_RST 11'h5dc
`define PBCD_CNT_MAX 8'hff
`define PBCD_CNT_ONE 8'h01
`define PBCD_BIT_TOP 15
`define PBCD_BIT_DONE 1
`define PBCD_BIT_FAIL 0
`define PBCD_BIT_CNTMODE 2
`define PBCD_GRADE_GOOD 2'b01
`define PBCD_IRQ_W 3
`define PBCD_IRQ_DONE 0
`define PBCD_IRQ_FAIL 1
`define PBCD_IRQ_SAT 2
`define PBCD_CNT_MSB 15
`define PBCD_CNT_LSB 8
`define PBCD_GAP_MSB 7
`define PBCD_LEN_MSB 10
`define PBCD_GRADE_MSB 9
`define PBCD_GRADE_LSB 8
`define PBCD_LOCK_MSB 1
`define PBCD_ZERO_CNT 8'h00
`define PBCD_ZERO_WORD 16'h0000
`endif

/* File: include/pbcd_pkg.sv */
// types for the bist and cable diagnostic register bank
package pbcd_pkg;
  typedef enum logic [1:0] {
    PBCD_DIAG_IDLE,
    PBCD_DIAG_RUN
  } pbcd_diag_state_t;
endpackage : pbcd_pkg

/* File: test/pbcd_regs_props.sv */
// assertions for the bist and cable diagnostic register bank
`timescale 1ns/1ps
`include "pbcd_params.svh"
module pbcd_regs_props (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [7:0] bist_gap_len,
  input wire logic [10:0] bist_pkt_len,
  input wire logic diag_start,
  input wire logic diag_done,
  input wire logic diag_fail
);
  wire cab = reg_addr == `PBCD_OFF_CABLE;
  wire gap = reg_addr == `PBCD_OFF_ERRGAP;
  wire len = reg_addr == `PBCD_OFF_PKTLEN;
  wire fin = diag_done || diag_fail;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  AST_START: assert property (reg_wr && cab && reg_wdata[15] && !diag_start |=> diag_start) else $error("no start");
  AST_IDLE: assert property (!diag_start && !(reg_wr && cab) |=> !diag_start) else $error("start rose");
  AST_SELFCLR: assert property (diag_start && fin |=> !diag_start) else $error("start kept");
  AST_GAP_WR: assert property (reg_wr && gap |=> bist_gap_len == $past(reg_wdata[7:0])) else $error("gap");
  AST_GAP_HOLD: assert property (!(reg_wr && gap) |=> $stable(bist_gap_len)) else $error("gap moved");
  AST_LEN_WR: assert property (reg_wr && len |=> bist_pkt_len == $past(reg_wdata[10:0])) else $error("len");
  AST_LEN_RSV: assert property (reg_rd && len |=> reg_rdata[15:11] == 5'h00) else $error("len rsv");
  AST_CAB_RSV: assert property (reg_rd && cab |=> reg_rdata[14:10] == 5'h00 && reg_rdata[7:2] == 6'h00) else $error("rsv");
  AST_RUN_FLAGS: assert property (reg_rd && cab && diag_start && !fin |=> reg_rdata[1:0] == 2'b00) else $error("flags");
  cover property (reg_wr && cab && reg_wdata[15]);
  cover property (diag_start && fin);
  cover property (reg_rd && gap);
endmodule : pbcd_regs_props
bind pbcd_regs pbcd_regs_props u_props (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bist_gap_len(bist_gap_len),
  .bist_pkt_len(bist_pkt_len), .diag_start(diag_start), .diag_done(diag_done), .diag_fail(diag_fail));

/* File: test/tb_pbcd_regs.sv */
// self-checking bench for the bist and cable diagnostic register bank
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin $display("[FAIL] %0t got %h exp %h", $time, a, b); n_mismatch++; end end
module tb_pbcd_regs;
  logic clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, bist_err_byte = 0, bist_cnt_mode = 0, rd_d = 0;
  logic diag_done = 0, diag_fail = 0;
  logic [1:0] diag_grade = 2'h0, pg;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, exp_v;
  logic [15:0] q[$];
  wire [15:0] reg_rdata;
  wire [7:0] bist_gap_len;
  wire [10:0] bist_pkt_len;
  wire diag_start, irq;
  int n_mismatch = 0, n_tests = 0, seed = 5, n, g, b;
  always #10 clk_sys = ~clk_sys;
  pbcd_regs uut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bist_err_byte(bist_err_byte), .bist_cnt_mode(bist_cnt_mode),
    .bist_gap_len(bist_gap_len), .bist_pkt_len(bist_pkt_len), .diag_start(diag_start), .diag_done(diag_done),
    .diag_fail(diag_fail), .diag_grade(diag_grade), .irq(irq));
  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_d) begin
      exp_v = q.pop_front();
      `CHK(reg_rdata, exp_v)
    end
    rd_d <= reg_rd;
  end
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task errs(input int k);
    @(posedge clk_sys);
    bist_err_byte <= 1'b1;
    repeat (k) @(posedge clk_sys);
    bist_err_byte <= 1'b0;
  endtask : errs
  task rst;
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
  endtask : rst
  task print_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    rst;
    rd(5'h1b, 16'h007d);
    rd(5'h1c, 16'h05dc);
    rd(5'h1e, 16'h0000);
    rd(5'h03, 16'h0000);
    wr(5'h1c, 16'hffff);
    rd(5'h1c, 16'h07ff);
    wr(5'h1b, 16'h7f33);
    bist_cnt_mode <= 1'b1;
    n = 1 + $unsigned($random(seed)) % 200;
    errs(n + 256);
    rd(5'h1b, {n[7:0], 8'h33});
    wr(5'h1b, 16'h8033);
    errs(4);
    rd(5'h1b, {n[7:0], 8'h33});
    rst;
    bist_cnt_mode <= 1'b0;
    errs(300);
    rd(5'h1b, 16'hff7d);
    for (b = 1; b < 4; b++) begin
      rst;
      n = 1 + $unsigned($random(seed)) % 200;
      errs(n);
      wr(5'h16, b[15:0]);
      errs(5);
      rd(5'h1b, {n[7:0], 8'h7d});
    end
    wr(5'h09, 16'h0003);
    pg = 2'h0;
    for (g = 1; g < 4; g++) begin
      wr(5'h1e, 16'h8000);
      rd(5'h1e, {1'b1, 5'h00, pg, 8'h00});
      @(posedge clk_sys);
      diag_done <= 1'b1;
      diag_fail <= g[0];
      diag_grade <= g[1:0];
      @(posedge clk_sys);
      diag_done <= 1'b0;
      diag_fail <= 1'b0;
      diag_grade <= ~g[1:0];
      rd(5'h1e, {6'h00, g[1:0], 6'h00, 1'b1, g[0]});
      pg = g[1:0];
    end
    `CHK(irq, 1'b1)
    rd(5'h08, 16'h0003);
    wr(5'h08, 16'h0007);
    rd(5'h08, 16'h0000);
    #1 `CHK(irq, 1'b0)
    for (g = 0; g < 8 && q.size() > 0; g++) @(posedge clk_sys);
    #1;
    if (q.size() > 0) n_mismatch++;
    print_verdict;
  end
endmodule : tb_pbcd_regs
